// [rtl/err_inj_pkg.sv]
// shared constants for the frame error injector
package err_inj_pkg;
	localparam int          DOM_BITS   = 6;     // forced dominant run length in bit times
	localparam int          POS_W      = 10;    // bit position width, covers longest fd frame
	localparam int          ID_W       = 29;    // extended identifier width
	localparam int          RUN_W      = 3;     // width of the dominant run counter
	localparam logic [9:0]  POS_RESET  = 10'h000;
	localparam logic [28:0] ID_RESET   = 29'h00000000;
	localparam logic [2:0]  RUN_LEN    = 3'h6;
	localparam logic [2:0]  RUN_RESET  = 3'h0;
	localparam logic [9:0]  POS_MAX    = 10'h3FF;
	typedef enum logic [1:0] {REP_OFF, REP_SKIP, REP_CORRUPT} rep_state_t;
endpackage

// [rtl/force_if.sv]
// carrier between the injector control and the dominant run driver
`timescale 1ns/10ps
interface force_if;
	logic bit_tick;
	logic start;
	logic abort;
	logic forcing;
	modport ctrl  (output bit_tick, output start, output abort, input forcing);
	modport drive (input bit_tick, input start, input abort, output forcing);
endinterface

// [rtl/dominant_run.sv]
// driver that holds the bus dominant for a fixed number of bit times
`timescale 1ns/10ps
module dominant_run
	import err_inj_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	force_if.drive   fi
);
	logic             forcing;
	logic             next_forcing;
	logic [RUN_W-1:0] left;
	logic [RUN_W-1:0] next_left;

	// ------------------------------------------------------------
	// run counter
	// ------------------------------------------------------------
	always_comb begin
		next_forcing = forcing;
		next_left    = left;
		if (fi.abort) begin
			next_forcing = 1'b0;
			next_left    = RUN_RESET;
		end else if (fi.start) begin
			// the start tick opens the first forced bit
			next_forcing = 1'b1;
			next_left    = RUN_LEN;
		end else if (forcing && fi.bit_tick) begin
			// each tick closes one forced bit, so the run follows the live bit rate
			next_left = left - 3'h1;
			if (left == 3'h1) begin
				next_forcing = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			forcing <= 1'b0;
			left    <= RUN_RESET;
		end else begin
			forcing <= next_forcing;
			left    <= next_left;
		end
	end

	assign fi.forcing = forcing;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	logic [RUN_W:0] ticks_seen;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ticks_seen <= 4'h0;
		end else if (fi.start) begin
			ticks_seen <= 4'h0;
		end else if (forcing && fi.bit_tick) begin
			ticks_seen <= ticks_seen + 4'h1;
		end
	end

	six_bits_a: assert property ($fell(forcing) && !$past(fi.abort) |-> ticks_seen == 4'h6)
		else $error("dominant run did not last six bit times");
	run_bound_a: assert property (forcing |-> ticks_seen < 4'h6)
		else $error("dominant run overran six bit times");
	start_edge_a: assert property (fi.start && !fi.abort |=> forcing)
		else $error("dominant run did not start at the selected bit");
endmodule // dominant_run

// [rtl/frame_error_injector.sv]
// frame error injector: one-shot and identifier-based repeated frame corruption
// Function
// - a fired injection drives six dominant bits in a row, breaking bit stuffing
// - two modes: one-shot once armed, and repeated tied to one identifier
// - one-shot hits only the first frame starting after arming
// - injection position must lie after the identifier, otherwise nothing fires
// - bit positions count every bus bit including stuff bits
// - frames are hit whether this node receives or transmits them
// - repeated mode only looks at frames with the configured identifier
// - repeated mode lets the skip count of matching frames pass first
// - repeated mode then corrupts corrupt_count matching frames, counted apart
// - apply starts repeated mode, disable stops all corruption at once
`timescale 1ns/10ps
module frame_error_injector
	import err_inj_pkg::*;
#(
	parameter int CNT_W = 8
) (
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	input  wire logic             bit_tick,
	input  wire logic             frame_start,
	input  wire logic             frame_end,
	input  wire logic             id_done,
	input  wire logic [ID_W-1:0]  rx_id,
	input  wire logic             rx_ext,
	input  wire logic [POS_W-1:0] one_shot_pos,
	input  wire logic             fire_one_shot,
	input  wire logic [ID_W-1:0]  rep_id,
	input  wire logic             rep_ext,
	input  wire logic [POS_W-1:0] rep_pos,
	input  wire logic [CNT_W-1:0] skip_count,
	input  wire logic [CNT_W-1:0] corrupt_count,
	input  wire logic             apply,
	input  wire logic             disable_inj,
	output logic                  force_dominant,
	output logic                  one_shot_armed,
	output logic                  rep_active,
	output logic                  pos_rejected
);
	function automatic logic [POS_W-1:0] inc_sat(input logic [POS_W-1:0] v);
		return (v == POS_MAX) ? v : v + 10'h001;
	endfunction

	// ------------------------------------------------------------
	// frame bit tracking
	// ------------------------------------------------------------
	logic             in_frame,   next_in_frame;
	logic [POS_W-1:0] bit_cnt,    next_bit_cnt;
	logic             id_seen,    next_id_seen;
	logic [POS_W-1:0] id_end_pos, next_id_end_pos;

	always_comb begin
		next_in_frame   = in_frame;
		next_bit_cnt    = bit_cnt;
		next_id_seen    = id_seen;
		next_id_end_pos = id_end_pos;
		if (frame_start) begin
			// start of frame bit is position zero
			next_in_frame = 1'b1;
			next_bit_cnt  = POS_RESET;
			next_id_seen  = 1'b0;
		end else if (frame_end) begin
			next_in_frame = 1'b0;
		end else if (in_frame && bit_tick) begin
			// every tick is a bus bit, stuff bits included
			next_bit_cnt = inc_sat(bit_cnt);
		end
		if (in_frame && id_done) begin
			next_id_seen    = 1'b1;
			next_id_end_pos = bit_cnt;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_frame   <= 1'b0;
			bit_cnt    <= POS_RESET;
			id_seen    <= 1'b0;
			id_end_pos <= POS_RESET;
		end else begin
			in_frame   <= next_in_frame;
			bit_cnt    <= next_bit_cnt;
			id_seen    <= next_id_seen;
			id_end_pos <= next_id_end_pos;
		end
	end

	// ------------------------------------------------------------
	// one-shot and repeated mode control
	// ------------------------------------------------------------
	rep_state_t       rep_state,   next_rep_state;
	logic             os_target,   next_os_target;
	logic             rep_target,  next_rep_target;
	logic             os_armed,    next_os_armed;
	logic [POS_W-1:0] os_pos,      next_os_pos;
	logic [ID_W-1:0]  cfg_id,      next_cfg_id;
	logic             cfg_ext,     next_cfg_ext;
	logic [POS_W-1:0] cfg_pos,     next_cfg_pos;
	logic [CNT_W-1:0] cfg_skip,    next_cfg_skip;
	logic [CNT_W-1:0] cfg_corrupt, next_cfg_corrupt;
	logic [CNT_W-1:0] skip_left,   next_skip_left;
	logic [CNT_W-1:0] corr_left,   next_corr_left;
	logic             rejected,    next_rejected;
	logic             id_match;
	logic             fire;
	logic [POS_W-1:0] aim_pos;

	assign id_match = in_frame && id_done && rep_state != REP_OFF
		&& rx_id == cfg_id && rx_ext == cfg_ext;
	// a one-shot target wins if both modes aim at the same frame
	assign aim_pos  = os_target ? os_pos : cfg_pos;
	assign fire     = in_frame && bit_tick && (os_target || rep_target) && id_seen
		&& inc_sat(bit_cnt) == aim_pos && aim_pos > id_end_pos && !disable_inj;

	always_comb begin
		next_rep_state   = rep_state;
		next_os_target   = os_target;
		next_rep_target  = rep_target;
		next_os_armed    = os_armed;
		next_os_pos      = os_pos;
		next_cfg_id      = cfg_id;
		next_cfg_ext     = cfg_ext;
		next_cfg_pos     = cfg_pos;
		next_cfg_skip    = cfg_skip;
		next_cfg_corrupt = cfg_corrupt;
		next_skip_left   = skip_left;
		next_corr_left   = corr_left;
		next_rejected    = rejected;
		if (fire_one_shot || apply) begin
			next_rejected = 1'b0;
		end
		if (fire_one_shot) begin
			next_os_armed = 1'b1;
			next_os_pos   = one_shot_pos;
		end
		if (frame_start && os_armed) begin
			// no frame direction is checked, own transmissions are hit too
			next_os_target = 1'b1;
			next_os_armed  = fire_one_shot;
		end
		if (apply) begin
			next_cfg_id      = rep_id;
			next_cfg_ext     = rep_ext;
			next_cfg_pos     = rep_pos;
			next_cfg_skip    = skip_count;
			next_cfg_corrupt = corrupt_count;
			next_skip_left   = skip_count;
			next_corr_left   = corrupt_count;
			next_rep_state   = (skip_count != '0) ? REP_SKIP : REP_CORRUPT;
		end else if (id_match) begin
			unique case (rep_state)
				REP_SKIP: begin
					next_skip_left = skip_left - CNT_W'(1);
					if (skip_left == CNT_W'(1)) begin
						next_rep_state = REP_CORRUPT;
					end
				end
				REP_CORRUPT: begin
					next_rep_target = corr_left != '0;
					next_corr_left  = corr_left - CNT_W'(1);
					if (corr_left <= CNT_W'(1)) begin
						next_skip_left = cfg_skip;
						next_corr_left = cfg_corrupt;
						next_rep_state = (cfg_skip != '0) ? REP_SKIP : REP_CORRUPT;
					end
				end
				REP_OFF: begin
				end
			endcase
		end
		if (in_frame && id_done && (os_target || next_rep_target)
				&& aim_pos <= bit_cnt) begin
			next_rejected = 1'b1;
		end
		if (fire || frame_end) begin
			next_os_target  = 1'b0;
			next_rep_target = 1'b0;
		end
		if (disable_inj) begin
			next_rep_state  = REP_OFF;
			next_os_target  = 1'b0;
			next_rep_target = 1'b0;
			next_os_armed   = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rep_state   <= REP_OFF;
			os_target   <= 1'b0;
			rep_target  <= 1'b0;
			os_armed    <= 1'b0;
			os_pos      <= POS_RESET;
			cfg_id      <= ID_RESET;
			cfg_ext     <= 1'b0;
			cfg_pos     <= POS_RESET;
			cfg_skip    <= '0;
			cfg_corrupt <= '0;
			skip_left   <= '0;
			corr_left   <= '0;
			rejected    <= 1'b0;
		end else begin
			rep_state   <= next_rep_state;
			os_target   <= next_os_target;
			rep_target  <= next_rep_target;
			os_armed    <= next_os_armed;
			os_pos      <= next_os_pos;
			cfg_id      <= next_cfg_id;
			cfg_ext     <= next_cfg_ext;
			cfg_pos     <= next_cfg_pos;
			cfg_skip    <= next_cfg_skip;
			cfg_corrupt <= next_cfg_corrupt;
			skip_left   <= next_skip_left;
			corr_left   <= next_corr_left;
			rejected    <= next_rejected;
		end
	end

	// ------------------------------------------------------------
	// dominant run driver
	// ------------------------------------------------------------
	force_if fi ();
	assign fi.bit_tick = bit_tick;
	assign fi.start    = fire;
	assign fi.abort    = disable_inj;

	dominant_run u_run (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.fi       (fi)
	);

	// the six dominant bits are what other nodes must report as a bus error
	assign force_dominant = fi.forcing;
	assign one_shot_armed = os_armed;
	assign rep_active     = rep_state != REP_OFF;
	assign pos_rejected   = rejected;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence arm_then_sof_s;
		os_armed && frame_start && !fire_one_shot && !disable_inj;
	endsequence
	sequence target_taken_s;
		!os_armed && os_target;
	endsequence

	os_single_a: assert property (arm_then_sof_s |=> target_taken_s)
		else $error("one-shot did not move to the next frame only");
	fire_pos_a: assert property ($rose(force_dominant) |-> id_seen && bit_cnt > id_end_pos
		&& bit_cnt == $past(aim_pos))
		else $error("injection fired inside the identifier");
	rep_idmatch_a: assert property ($rose(rep_target) |-> $past(id_match))
		else $error("repeated target taken without identifier match");
	skip_pass_a: assert property (id_match && rep_state == REP_SKIP && !apply
		|=> !rep_target)
		else $error("skipped frame was targeted");
	corrupt_dec_a: assert property (id_match && rep_state == REP_CORRUPT
		&& corr_left > CNT_W'(1) && !apply && !disable_inj
		|=> rep_target && corr_left == $past(corr_left) - CNT_W'(1))
		else $error("corrupt count not consumed");
	refill_a: assert property (id_match && rep_state == REP_CORRUPT && corr_left == CNT_W'(1)
		&& !apply && !disable_inj |=> corr_left == cfg_corrupt && skip_left == cfg_skip)
		else $error("skip and corrupt counts not reloaded");
	apply_start_a: assert property (rep_state == REP_OFF && !apply |=> rep_state == REP_OFF)
		else $error("repeated mode started without apply");
	disable_stop_a: assert property (disable_inj |=> !force_dominant && !rep_target
		&& !os_target && rep_state == REP_OFF ##1 !force_dominant)
		else $error("corruption continued after disable");
	count_bits_a: assert property (in_frame && bit_tick && !frame_start && !frame_end
		&& bit_cnt != POS_MAX |=> bit_cnt == $past(bit_cnt) + 10'h001)
		else $error("bit position missed a bus bit");
endmodule // frame_error_injector

// [tb/can_node_model.sv]
// behavioural bus peer: frames traffic and watches the bus for a dominant run
`timescale 1ns/10ps
module can_node_model
	import err_inj_pkg::*;
#(
	parameter int ID_END = 11
) (
	input  wire logic        core_clk,
	input  wire logic        force_dominant,
	output logic             bit_tick,
	output logic             frame_start,
	output logic             frame_end,
	output logic             id_done,
	output logic [ID_W-1:0]  rx_id,
	output logic             rx_ext,
	output int               hit_pos,
	output int               dom_run
);
	initial begin
		bit_tick    = 1'b0;
		frame_start = 1'b0;
		frame_end   = 1'b0;
		id_done     = 1'b0;
		rx_id       = '0;
		rx_ext      = 1'b0;
	end
	// --------------------------------------------------------------
	// one frame, four clocks a bit; the bus is sampled at bit end
	// --------------------------------------------------------------
	task automatic send_frame(input logic [ID_W-1:0] id, input logic ext, input int nbits);
		int run;
		run     = 0;
		hit_pos = -1;
		dom_run = 0;
		for (int p = 0; p < nbits && !(dom_run == DOM_BITS && run == 0); p++) begin
			@(posedge core_clk);
			bit_tick    <= 1'b1;
			frame_start <= (p == 0);
			@(posedge core_clk);
			bit_tick    <= 1'b0;
			frame_start <= 1'b0;
			id_done     <= (p == ID_END);
			// identifier is only valid with id_done, garbage otherwise
			rx_id       <= (p == ID_END) ? id : ~id;
			rx_ext      <= (p == ID_END) ? ext : ~ext;
			@(posedge core_clk);
			id_done <= 1'b0;
			@(posedge core_clk);
			#1;
			run = force_dominant ? run + 1 : 0;
			if (run == 1 && hit_pos < 0)
				hit_pos = p;
			if (run > dom_run)
				dom_run = run;
		end
		// a full dominant run ends the frame early as a bus error
		@(posedge core_clk);
		frame_end <= 1'b1;
		@(posedge core_clk);
		frame_end <= 1'b0;
	endtask
endmodule // can_node_model

// [tb/test_frame_error_injector.sv]
// self-checking bench for the frame error injector
`timescale 1ns/10ps
module test_frame_error_injector;
	import err_inj_pkg::*;
	localparam int ID_END = 11;
	localparam int NBITS  = 60;
	logic             core_clk      = 1'b0;
	logic             arst_n        = 1'b0;
	logic [POS_W-1:0] one_shot_pos  = '0;
	logic             fire_one_shot = 1'b0;
	logic [ID_W-1:0]  rep_id        = '0;
	logic             rep_ext       = 1'b0;
	logic [POS_W-1:0] rep_pos       = '0;
	logic [7:0]       skip_count    = 8'h00;
	logic [7:0]       corrupt_count = 8'h00;
	logic             apply         = 1'b0;
	logic             disable_inj   = 1'b0;
	logic             bit_tick, frame_start, frame_end, id_done, rx_ext;
	logic [ID_W-1:0]  rx_id;
	logic             force_dominant, one_shot_armed, rep_active, pos_rejected;
	int               hit_pos, dom_run;
	int               bad_count  = 0;
	int               n_compared = 0;
	always #5 core_clk = ~core_clk;
	frame_error_injector dut (
		.core_clk(core_clk), .arst_n(arst_n), .bit_tick(bit_tick),
		.frame_start(frame_start), .frame_end(frame_end), .id_done(id_done),
		.rx_id(rx_id), .rx_ext(rx_ext), .one_shot_pos(one_shot_pos),
		.fire_one_shot(fire_one_shot), .rep_id(rep_id), .rep_ext(rep_ext),
		.rep_pos(rep_pos), .skip_count(skip_count), .corrupt_count(corrupt_count),
		.apply(apply), .disable_inj(disable_inj), .force_dominant(force_dominant),
		.one_shot_armed(one_shot_armed), .rep_active(rep_active),
		.pos_rejected(pos_rejected)
	);
	can_node_model #(.ID_END(ID_END)) node (
		.core_clk(core_clk), .force_dominant(force_dominant), .bit_tick(bit_tick),
		.frame_start(frame_start), .frame_end(frame_end), .id_done(id_done),
		.rx_id(rx_id), .rx_ext(rx_ext), .hit_pos(hit_pos), .dom_run(dom_run)
	);
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	// repeated mode hits the matching frames after the first s of every s + c
	function automatic int exp_hit(input int k, input int s, input int c, input int p);
		return ((k % (s + c)) >= s) ? p : -1;
	endfunction
	// 0 arms one-shot, 1 applies repeated mode, 2 disables
	task automatic cmd(input int which);
		@(posedge core_clk);
		fire_one_shot <= (which == 0);
		apply         <= (which == 1);
		disable_inj   <= (which == 2);
		@(posedge core_clk);
		fire_one_shot <= 1'b0;
		apply         <= 1'b0;
		disable_inj   <= 1'b0;
		#1;
	endtask
	task automatic frame(input logic [ID_W-1:0] id, input logic ext, input int exp_pos);
		node.send_frame(id, ext, NBITS);
		chk("hit position", exp_pos, hit_pos);
		chk("dominant run", (exp_pos < 0) ? 0 : DOM_BITS, dom_run);
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// --------------------------------------------------------------
	// scenarios
	// --------------------------------------------------------------
	initial begin
		int p;
		int s;
		int c;
		logic [ID_W-1:0] id;
		logic e;
		void'($urandom(32'h48BF3A8B));
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		#1;
		chk("armed after reset", 0, one_shot_armed);
		chk("active after reset", 0, rep_active);
		chk("force after reset", 0, force_dominant);
		p = ID_END + 1 + $urandom_range(0, 30);
		one_shot_pos <= POS_W'(p);
		cmd(0);
		chk("armed", 1, one_shot_armed);
		frame(29'h0000123, 1'b0, p);
		chk("armed", 0, one_shot_armed);
		frame(29'h0000123, 1'b0, -1);
		// last identifier bit is the awkward boundary of the refusal
		one_shot_pos <= POS_W'(ID_END);
		cmd(0);
		frame(29'h0000456, 1'b0, -1);
		chk("rejected", 1, pos_rejected);
		id = ID_W'($urandom_range(0, 2047));
		e = 1'($urandom_range(0, 1));
		s = $urandom_range(0, 2);
		c = $urandom_range(1, 2);
		p = ID_END + 1 + $urandom_range(0, 30);
		rep_id        <= id;
		rep_ext       <= e;
		rep_pos       <= POS_W'(p);
		skip_count    <= 8'(s);
		corrupt_count <= 8'(c);
		frame(id, e, -1);
		cmd(1);
		chk("active", 1, rep_active);
		chk("rejected", 0, pos_rejected);
		for (int k = 0; k < 2 * (s + c); k++) begin
			frame(id ^ 29'h0000001, e, -1);
			// same number in the other identifier format is a different frame
			frame(id, ~e, -1);
			frame(id, e, exp_hit(k, s, c, p));
		end
		// a zero corrupt count walks matching frames but never hits one
		skip_count    <= 8'h00;
		corrupt_count <= 8'h00;
		cmd(1);
		frame(id, e, -1);
		frame(id, e, -1);
		// disable lands within the first forced bit of a running dominant run
		corrupt_count <= 8'h03;
		cmd(1);
		fork
			node.send_frame(id, e, NBITS);
			begin
				wait (force_dominant === 1'b1);
				cmd(2);
			end
		join
		chk("cut run", 1, dom_run < DOM_BITS);
		chk("active", 0, rep_active);
		frame(id, e, -1);
		// disable also drops a one-shot still waiting for its frame
		one_shot_pos <= POS_W'(p);
		cmd(0);
		cmd(2);
		chk("armed", 0, one_shot_armed);
		frame(id, e, -1);
		final_report();
	end
	// a hang is cut well past the few thousand cycles the run needs
	initial begin
		repeat (40000) @(posedge core_clk);
		bad_count++;
		final_report();
	end
endmodule // test_frame_error_injector
